/* core/slpctl_cfg.svh */
// Constants for the sleep-mode clock gating controller.
`ifndef SLPCTL_CFG_SVH
`define SLPCTL_CFG_SVH
`define SLPCTL_MODE_W      3
`define SLPCTL_MODE_IDLE   3'h0
`define SLPCTL_MODE_ADCNR  3'h1
`define SLPCTL_MODE_PDOWN  3'h2
`define SLPCTL_MODE_PSAVE  3'h3
`define SLPCTL_MODE_STBY   3'h6
`define SLPCTL_MODE_XSTBY  3'h7
`define SLPCTL_DOM_W       8
`define SLPCTL_DOM_CPU     0
`define SLPCTL_DOM_SRAM    1
`define SLPCTL_DOM_TMR     2
`define SLPCTL_DOM_SPI     3
`define SLPCTL_DOM_IRQ     4
`define SLPCTL_DOM_ADC     5
`define SLPCTL_DOM_ATMR    6
`define SLPCTL_DOM_OSC     7
`define SLPCTL_ALL_ON      8'hff
`endif

/* core/slpctl_pkg.sv */
// Types for the sleep-mode clock gating controller.
`include "slpctl_cfg.svh"
package slpctl_pkg;
    typedef enum logic [1:0] {
        SLPCTL_RUN   = 2'h0,
        SLPCTL_SLEEP = 2'h1,
        SLPCTL_WAKE  = 2'h2
    } slpctl_state_t;

    typedef struct packed {
        slpctl_state_t                 state;
        logic [`SLPCTL_MODE_W-1:0]     mode;
        logic [`SLPCTL_DOM_W-1:0]      enables;
        logic                          bad_mode;
    } slpctl_ctl_t;
endpackage

/* core/slpctl_gate_if.sv */
// Carrier between the controller and its gating-table module.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
interface slpctl_gate_if;
    logic [`SLPCTL_MODE_W-1:0] mode;
    logic [`SLPCTL_DOM_W-1:0]  enables;
    logic                      valid;
    modport ctl (output mode, input enables, input valid);
    modport tbl (input mode, output enables, output valid);
endinterface

/* core/slpctl_gate_table.sv */
// Gating table: which clock domains run in each sleep mode.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
module slpctl_gate_table
(
    slpctl_gate_if.tbl gif
);
    function automatic logic [`SLPCTL_DOM_W-1:0] dom(input int idx);
        dom = `SLPCTL_DOM_W'(1) << idx;
    endfunction

    always_comb
    begin
        gif.valid   = 1'b1;
        gif.enables = `SLPCTL_DOM_W'(0);
        case (gif.mode)
            `SLPCTL_MODE_IDLE:
                gif.enables = `SLPCTL_ALL_ON & ~dom(`SLPCTL_DOM_CPU);
            `SLPCTL_MODE_ADCNR:
                gif.enables = dom(`SLPCTL_DOM_ATMR) | dom(`SLPCTL_DOM_ADC)
                            | dom(`SLPCTL_DOM_OSC) | dom(`SLPCTL_DOM_IRQ);
            `SLPCTL_MODE_PDOWN:
                gif.enables = `SLPCTL_DOM_W'(0);
            `SLPCTL_MODE_PSAVE:
                gif.enables = dom(`SLPCTL_DOM_ATMR);
            `SLPCTL_MODE_STBY:
                gif.enables = dom(`SLPCTL_DOM_OSC);
            `SLPCTL_MODE_XSTBY:
                gif.enables = dom(`SLPCTL_DOM_OSC) | dom(`SLPCTL_DOM_ATMR);
            default:
            begin
                gif.valid   = 1'b0;
                gif.enables = `SLPCTL_ALL_ON;
            end
        endcase
    end
endmodule // slpctl_gate_table

/* core/slpctl_top.sv */
// Sleep-mode controller: takes sleep requests and gates the clock domains.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
// How it works
// - Idle stops only the processor clock.
// - Power-down halts oscillator; interrupt or reset wakes.
// - Power-save keeps only the asynchronous timer.
// - ADC noise-reduction keeps ADC, asynchronous timer, oscillator and interrupt domain.
// - Standby keeps only the main oscillator running.
// - Extended standby keeps oscillator and asynchronous timer.
// - Six selectable modes; selected gating set applied.
module slpctl_top
(
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      sleep_req_i,
    input  wire logic [`SLPCTL_MODE_W-1:0] sleep_mode_i,
    input  wire logic                      irq_wake_i,
    output logic                           sleep_ack_o,
    output logic                           sleeping_o,
    output logic                           mode_err_o,
    output logic [`SLPCTL_MODE_W-1:0]      active_mode_o,
    output logic [`SLPCTL_DOM_W-1:0]       clk_en_o
);
    logic                 rst_sync1_reg;
    logic                 rst_sync2_reg;
    logic                 irq_sync1_reg;
    logic                 irq_sync2_reg;
    slpctl_pkg::slpctl_ctl_t ctl_reg;
    slpctl_pkg::slpctl_ctl_t ctl_next;
    slpctl_gate_if           gif ();

    // The reset is released synchronously so no domain leaves reset a cycle apart.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // Wake interrupts come from domains that may be gated, so they are synchronised.
    always_ff @(posedge clk_i or negedge rst_sync2_reg)
    begin
        if (!rst_sync2_reg)
        begin
            irq_sync1_reg <= 1'b0;
            irq_sync2_reg <= 1'b0;
        end
        else
        begin
            irq_sync1_reg <= irq_wake_i;
            irq_sync2_reg <= irq_sync1_reg;
        end
    end

    slpctl_gate_table u_table
    (
        .gif (gif.tbl)
    );

    assign gif.mode = sleep_mode_i;

    always_comb
    begin
        ctl_next = ctl_reg;
        case (ctl_reg.state)
            slpctl_pkg::SLPCTL_RUN:
            begin
                ctl_next.bad_mode = 1'b0;
                if (sleep_req_i && !irq_sync2_reg)
                begin
                    if (gif.valid)
                    begin
                        ctl_next.state   = slpctl_pkg::SLPCTL_SLEEP;
                        ctl_next.mode    = sleep_mode_i;
                        ctl_next.enables = gif.enables;
                    end
                    else
                    begin
                        // An unknown code is refused rather than guessed at.
                        ctl_next.bad_mode = 1'b1;
                    end
                end
            end
            slpctl_pkg::SLPCTL_SLEEP:
            begin
                // Power-down and the others hold their gating until a wake event.
                if (irq_sync2_reg)
                begin
                    ctl_next.state   = slpctl_pkg::SLPCTL_WAKE;
                    ctl_next.enables = `SLPCTL_ALL_ON;
                end
            end
            slpctl_pkg::SLPCTL_WAKE:
            begin
                // Waiting for the request to drop prevents an instant re-sleep.
                if (!sleep_req_i)
                begin
                    ctl_next.state = slpctl_pkg::SLPCTL_RUN;
                end
            end
            default:
            begin
                ctl_next.state   = slpctl_pkg::SLPCTL_RUN;
                ctl_next.enables = `SLPCTL_ALL_ON;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_sync2_reg)
    begin
        if (!rst_sync2_reg)
        begin
            ctl_reg.state    <= slpctl_pkg::SLPCTL_RUN;
            ctl_reg.mode     <= `SLPCTL_MODE_IDLE;
            ctl_reg.enables  <= `SLPCTL_ALL_ON;
            ctl_reg.bad_mode <= 1'b0;
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    assign clk_en_o      = ctl_reg.enables;
    assign active_mode_o = ctl_reg.mode;
    assign sleeping_o    = (ctl_reg.state == slpctl_pkg::SLPCTL_SLEEP);
    assign sleep_ack_o   = (ctl_reg.state == slpctl_pkg::SLPCTL_SLEEP);
    assign mode_err_o    = ctl_reg.bad_mode;
endmodule // slpctl_top

/* testbench/slpctl_top_asserts.sv */
// Checker that watches the ports of the sleep-mode controller.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
module slpctl_top_asserts
(
    input wire logic                      clk_i,
    input wire logic                      nrst_i,
    input wire logic                      sleep_req_i,
    input wire logic [`SLPCTL_MODE_W-1:0] sleep_mode_i,
    input wire logic                      irq_wake_i,
    input wire logic                      sleep_ack_o,
    input wire logic                      sleeping_o,
    input wire logic                      mode_err_o,
    input wire logic [`SLPCTL_MODE_W-1:0] active_mode_o,
    input wire logic [`SLPCTL_DOM_W-1:0]  clk_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_ack; $rose(sleep_ack_o) |-> $past(sleep_req_i) && sleeping_o; endproperty
    a_ack: assert property (p_ack) else $error("ack differs");
    property p_run; !sleeping_o |-> clk_en_o == 8'hff; endproperty
    a_run: assert property (p_run) else $error("gated awake");
    property p_idle; sleeping_o && active_mode_o == 3'h0 |-> clk_en_o == 8'hfe; endproperty
    a_idle: assert property (p_idle) else $error("idle set");
    property p_adc; sleeping_o && active_mode_o == 3'h1 |-> clk_en_o == 8'hf0; endproperty
    a_adc: assert property (p_adc) else $error("adc set");
    property p_pdn; sleeping_o && active_mode_o == 3'h2 |-> clk_en_o == 8'h00; endproperty
    a_pdn: assert property (p_pdn) else $error("pdown set");
    property p_psv; sleeping_o && active_mode_o == 3'h3 |-> clk_en_o == 8'h40; endproperty
    a_psv: assert property (p_psv) else $error("psave set");
    property p_stb; sleeping_o && active_mode_o == 3'h6 |-> clk_en_o == 8'h80; endproperty
    a_stb: assert property (p_stb) else $error("stby set");
    property p_xst; sleeping_o && active_mode_o == 3'h7 |-> clk_en_o == 8'hc0; endproperty
    a_xst: assert property (p_xst) else $error("xstby set");
    property p_wake; sleeping_o && $rose(irq_wake_i) |-> ##[1:4] !sleeping_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_err; mode_err_o |-> $past(sleep_mode_i[2:1]) == 2'h2 || $past(sleep_mode_i[2:1], 2) == 2'h2; endproperty
    a_err: assert property (p_err) else $error("bad refusal");
endmodule // slpctl_top_asserts
bind slpctl_top slpctl_top_asserts slpctl_top_asserts_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .sleep_req_i(sleep_req_i), .sleep_mode_i(sleep_mode_i), .irq_wake_i(irq_wake_i), .sleep_ack_o(sleep_ack_o),
    .sleeping_o(sleeping_o), .mode_err_o(mode_err_o), .active_mode_o(active_mode_o), .clk_en_o(clk_en_o));

/* testbench/slpctl_cpu_model.sv */
// Processor core model that requests sleep and raises wake interrupts.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
module slpctl_cpu_model
(
    input  wire logic                      clk_i,
    input  wire logic                      go_i,
    input  wire logic [`SLPCTL_MODE_W-1:0] code_i,
    input  wire logic                      wake_i,
    output logic                           sleep_req_o = 1'b0,
    output logic [`SLPCTL_MODE_W-1:0]      sleep_mode_o = 3'h0,
    output logic                           irq_o = 1'b0
);
    // Launching on the falling edge keeps the controller's sampling edge race free.
    always @(negedge clk_i)
    begin
        sleep_req_o <= go_i;
        sleep_mode_o <= code_i;
        irq_o <= wake_i;
    end
endmodule // slpctl_cpu_model

/* testbench/test_sleep_mode_clock_gating.sv */
// Self-checking bench for the sleep-mode clock gating controller.
`timescale 1ns/10ps
`include "slpctl_cfg.svh"
module test_sleep_mode_clock_gating;
    logic                      clk = 1'b0;
    logic                      nrst = 1'b0;
    logic                      go = 1'b0;
    logic                      wake = 1'b0;
    logic [2:0]                code = 3'h0;
    logic                      req, irq, ack, slp, err;
    logic [`SLPCTL_MODE_W-1:0] mode, amode;
    logic [`SLPCTL_DOM_W-1:0]  en;
    int                        err_total = 0;
    int                        checks = 0;
    always #2.5 clk = ~clk;
    slpctl_cpu_model slpctl_cpu_model_inst (.clk_i(clk), .go_i(go), .code_i(code), .wake_i(wake),
        .sleep_req_o(req), .sleep_mode_o(mode), .irq_o(irq));
    slpctl_top slpctl_top_inst (.clk_i(clk), .nrst_i(nrst), .sleep_req_i(req), .sleep_mode_i(mode),
        .irq_wake_i(irq), .sleep_ack_o(ack), .sleeping_o(slp), .mode_err_o(err), .active_mode_o(amode),
        .clk_en_o(en));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input logic g, input logic [2:0] c, input logic w, input int n);
        @(posedge clk);
        go = g;
        code = c;
        wake = w;
        repeat (n) @(negedge clk);
    endtask
    task automatic conclude;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_modes;
        logic [2:0] cd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        logic [7:0] st [6] = '{8'hfe, 8'hf0, 8'h00, 8'h40, 8'h80, 8'hc0};
        for (int i = 0; i < 6; i++)
        begin
            step(1'b1, cd[i], 1'b0, 3);
            check(en, st[i]);
            check({7'h0, ack}, 8'h01);
            check({5'h0, amode}, {5'h0, cd[i]});
            step(1'b1, cd[i], 1'b1, 5);
            check(en, 8'hff);
            check({7'h0, slp}, 8'h00);
            step(1'b0, cd[i], 1'b0, 3);
        end
    endtask
    task automatic t_bad;
        for (int c = 4; c < 6; c++)
        begin
            step(1'b1, 3'(c), 1'b0, 2);
            check({7'h0, err}, 8'h01);
            check(en, 8'hff);
            step(1'b0, 3'h0, 1'b0, 3);
            check({7'h0, err}, 8'h00);
        end
    endtask
    task automatic t_irq_block;
        step(1'b0, 3'h0, 1'b1, 4);
        step(1'b1, 3'h2, 1'b1, 1);
        // Every cycle is looked at, so a one-cycle dip into sleep cannot hide.
        repeat (3)
        begin
            @(negedge clk);
            check(en, 8'hff);
            check({7'h0, slp}, 8'h00);
        end
        step(1'b0, 3'h0, 1'b0, 3);
    endtask
    task automatic t_reset;
        step(1'b1, 3'h2, 1'b0, 3);
        check(en, 8'h00);
        nrst = 1'b0;
        go = 1'b0;
        @(negedge clk);
        check(en, 8'hff);
        check({7'h0, slp}, 8'h00);
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check({5'h0, amode}, 8'h00);
        step(1'b1, 3'h7, 1'b0, 3);
        check(en, 8'hc0);
        step(1'b1, 3'h7, 1'b1, 5);
        check(en, 8'hff);
        step(1'b0, 3'h0, 1'b0, 3);
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_modes();
        t_bad();
        t_irq_block();
        t_reset();
        conclude();
    end
    // The tests need well under a microsecond, so this only trips on a hang.
    initial
    begin
        #5000;
        err_total++;
        conclude();
    end
endmodule // test_sleep_mode_clock_gating
